// ### cfc_pkg.sv
// shared constants and carrier types for the capability format codec
package cfc_pkg;

  localparam int CFC_XLEN = 64;
  localparam int CFC_MW   = 14;
  localparam int CFC_EW   = 6;
  localparam logic [6:0] CFC_MAX_E = 7'(CFC_XLEN - CFC_MW + 2);
  localparam logic CFC_LEN_MSB_OPTION   = 1'b0;
  localparam logic CFC_MODE_IN_PERM_OPT = 1'b0;
  localparam logic [7:0] CFC_FULL_PERM_VALUE = 8'hFF;
  localparam logic [13:0] CFC_REPR_OFFSET = 14'h1000;

  // metadata word field positions
  localparam int CFC_B_LSB   = 0;
  localparam int CFC_T_LSB   = 14;
  localparam int CFC_EF_BIT  = 26;
  localparam int CFC_CT_BIT  = 27;
  localparam int CFC_SDP_LSB = 28;
  localparam int CFC_SDP_W   = 4;
  localparam int CFC_AP_LSB  = 32;
  localparam int CFC_AP_W    = 8;
  localparam int CFC_GL_BIT  = 40;
  localparam int CFC_M_BIT   = 52;
  localparam logic [63:0] CFC_RSVD_MASK = 64'hFFEF_FE00_0000_0000;

  // permission bit positions inside the architectural field
  localparam int CFC_P_CAP = 0;
  localparam int CFC_P_WR  = 1;
  localparam int CFC_P_RD  = 2;
  localparam int CFC_P_EX  = 3;
  localparam int CFC_P_SYS = 4;
  localparam int CFC_P_LM  = 5;
  localparam int CFC_P_LG  = 6;
  localparam int CFC_P_SL  = 7;

  // control register bits
  localparam int CFC_C_HYBRID = 0;
  localparam int CFC_C_LEVELS = 1;
  localparam int CFC_C_SENTRY = 2;

  // register byte offsets
  localparam logic [7:0] CFC_CTRL_OFF    = 8'h00;
  localparam logic [7:0] CFC_ADDR_LO_OFF = 8'h04;
  localparam logic [7:0] CFC_ADDR_HI_OFF = 8'h08;
  localparam logic [7:0] CFC_META_LO_OFF = 8'h0C;
  localparam logic [7:0] CFC_META_HI_OFF = 8'h10;
  localparam logic [7:0] CFC_TAG_OFF     = 8'h14;
  localparam logic [7:0] CFC_OP_OFF      = 8'h18;
  localparam logic [7:0] CFC_ACC_LO_OFF  = 8'h1C;
  localparam logic [7:0] CFC_ACC_HI_OFF  = 8'h20;
  localparam logic [7:0] CFC_STAT_OFF    = 8'h24;
  localparam logic [7:0] CFC_BASE_LO_OFF = 8'h28;
  localparam logic [7:0] CFC_BASE_HI_OFF = 8'h2C;
  localparam logic [7:0] CFC_TOP_LO_OFF  = 8'h30;
  localparam logic [7:0] CFC_TOP_HI_OFF  = 8'h34;
  localparam logic [7:0] CFC_RES_LO_OFF  = 8'h38;
  localparam logic [7:0] CFC_RES_HI_OFF  = 8'h3C;
  localparam logic [7:0] CFC_PERM_OFF    = 8'h40;
  localparam logic [7:0] CFC_LINK_HI_OFF = 8'h44;
  localparam logic [7:0] CFC_RADR_LO_OFF = 8'h48;
  localparam logic [7:0] CFC_RADR_HI_OFF = 8'h4C;

  typedef enum logic [2:0] {
    CFC_OP_DECODE  = 3'h0,
    CFC_OP_SETADDR = 3'h1,
    CFC_OP_JUMP    = 3'h2,
    CFC_OP_SENTRY  = 3'h3,
    CFC_OP_CHECK   = 3'h4,
    CFC_OP_BUILD   = 3'h5
  } cfc_op_e;

  typedef struct packed {
    logic        tag;
    logic [63:0] meta;
    logic [63:0] addr;
  } cfc_cap_s;

  typedef struct packed {
    logic [63:0] base;
    logic [64:0] top;
    logic        malformed;
    logic        infinite;
    logic [6:0]  scale;
  } cfc_bounds_s;

  typedef struct packed {
    logic [2:0]  ctrl;
    cfc_cap_s    src;
    logic [63:0] acc;
    cfc_cap_s    res;
    logic [63:0] link_meta;
    logic        link_tag;
    logic [63:0] base;
    logic [64:0] top;
    logic        malformed;
    logic        valid;
    logic        access_ok;
    logic        infinite;
    logic        op_err;
    logic        full_perm;
    logic [11:0] perm_rd;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } cfc_state_s;

endpackage : cfc_pkg

// ### cfc_bounds_dec.sv
// bounds decoder: base, top and malformed flag from a capability
`timescale 1ns/1ps
module cfc_bounds_dec
  import cfc_pkg::*;
(
  input  wire cfc_cap_s    cap,
  output cfc_bounds_s      bnd
);

  logic        ef;
  logic [13:0] bf;
  logic [11:0] tf;
  logic [5:0]  ecode;
  logic [6:0]  e;
  logic [6:0]  sh;
  logic [13:0] b;
  logic [13:0] t;
  logic [13:0] r;
  logic [13:0] a_mid;
  logic        lc;
  logic        lmsb;
  logic        a_lt;
  logic        b_lt;
  logic        t_lt;
  logic [79:0] upper;
  logic [79:0] up_b;
  logic [79:0] up_t;
  logic [79:0] base_w;
  logic [79:0] top_w;

  always_comb begin
    ef    = cap.meta[CFC_EF_BIT];
    bf    = cap.meta[CFC_B_LSB +: CFC_MW];
    tf    = cap.meta[CFC_T_LSB +: CFC_MW - 2];
    ecode = {tf[2:0], bf[2:0]};
    if (ef) begin
      e    = 7'h00;
      b    = bf;
      t    = {2'b00, tf};
      lc   = tf < bf[11:0];
      lmsb = CFC_LEN_MSB_OPTION;
    end else begin
      e    = CFC_MAX_E - {1'b0, ecode};
      b    = {bf[13:3], 3'h0};
      t    = {2'b00, tf[11:3], 3'h0};
      lc   = tf[11:3] < bf[11:3];
      lmsb = 1'b1;
    end
    t[13:12] = b[13:12] + {1'b0, lc} + {1'b0, lmsb};
    // negative scale shows as the sign bit of the 7-bit result
    bnd.malformed = !ef && ((e == CFC_MAX_E && b != 14'h0000) ||
                    (e == CFC_MAX_E - 7'h01 && b[13]) || e[6]);
    bnd.infinite  = !ef && e == CFC_MAX_E && !bnd.malformed;
    bnd.scale     = e;
    // region below base keeps a quarter of the span representable
    r     = b - CFC_REPR_OFFSET;
    a_mid = 14'(cap.addr >> e[5:0]);
    a_lt  = a_mid < r;
    b_lt  = b < r;
    t_lt  = t < r;
    sh    = e + 7'(CFC_MW);
    upper = {16'h0000, cap.addr} >> sh;
    if (a_lt == b_lt) begin
      up_b = upper;
    end else if (b_lt) begin
      up_b = upper + 80'h1;
    end else begin
      up_b = upper - 80'h1;
    end
    if (a_lt == t_lt) begin
      up_t = upper;
    end else if (t_lt) begin
      up_t = upper + 80'h1;
    end else begin
      up_t = upper - 80'h1;
    end
    base_w   = (up_b << sh) + ({66'h0, b} << e[5:0]);
    top_w    = (up_t << sh) + ({66'h0, t} << e[5:0]);
    bnd.base = base_w[63:0];
    bnd.top  = top_w[64:0];
    if (!e[6] && e < CFC_MAX_E - 7'h01 &&
        (bnd.top[64:63] - {1'b0, bnd.base[63]}) > 2'h1) begin
      bnd.top[64] = ~bnd.top[64];
    end
    if (bnd.malformed) begin
      bnd.base = 64'h0;
      bnd.top  = 65'h0;
    end
  end

endmodule : cfc_bounds_dec

// ### cfc_codec.sv
// capability format codec: apb register front end and checks
`timescale 1ns/1ps
module cfc_codec
  import cfc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  cfc_state_s  s_reg;
  cfc_state_s  s_next;
  cfc_cap_s    probe;
  cfc_bounds_s bnd_src;
  cfc_bounds_s bnd_probe;
  logic        setup_hit;
  logic        done_wr;
  logic        mapped;
  logic [31:0] rd_val;
  logic        src_ok;
  logic        src_good;
  logic [7:0]  ap;
  logic [7:0]  grant;
  logic        hyb;
  logic        lvl;

  // same metadata at the new address must give the same bounds
  assign probe = {s_reg.src.tag, s_reg.src.meta, s_reg.acc};

  cfc_bounds_dec u_dec_src (
    .cap (s_reg.src),
    .bnd (bnd_src)
  );

  cfc_bounds_dec u_dec_probe (
    .cap (probe),
    .bnd (bnd_probe)
  );

  assign hyb = s_reg.ctrl[CFC_C_HYBRID];
  assign lvl = s_reg.ctrl[CFC_C_LEVELS];
  assign ap  = s_reg.src.meta[CFC_AP_LSB +: CFC_AP_W];

  // validity of the staged capability metadata
  always_comb begin
    src_ok = (s_reg.src.meta & CFC_RSVD_MASK) == 64'h0;
    if (!hyb && s_reg.src.meta[CFC_M_BIT]) begin
      src_ok = 1'b0;
    end
    if (!lvl && s_reg.src.meta[CFC_GL_BIT]) begin
      src_ok = 1'b0;
    end
    if (!lvl && ap[CFC_P_SL:CFC_P_LG] != 2'b11) begin
      src_ok = 1'b0;
    end
    if (!ap[CFC_P_EX] && s_reg.src.meta[CFC_M_BIT]) begin
      src_ok = 1'b0;
    end
    src_good = s_reg.src.tag && src_ok && !bnd_src.malformed;
  end

  // effective permissions: own bit plus its prerequisites, where either read or write is enough for cap
  always_comb begin
    grant[CFC_P_WR]  = ap[CFC_P_WR];
    grant[CFC_P_RD]  = ap[CFC_P_RD];
    grant[CFC_P_EX]  = ap[CFC_P_EX];
    grant[CFC_P_CAP] = ap[CFC_P_CAP] &&
                       (ap[CFC_P_RD] || ap[CFC_P_WR]);
    grant[CFC_P_SYS] = ap[CFC_P_SYS] && ap[CFC_P_EX];
    grant[CFC_P_LM]  = ap[CFC_P_LM] && grant[CFC_P_CAP] &&
                       ap[CFC_P_RD];
    // the two upper bits mean nothing without privilege levels
    grant[CFC_P_LG]  = lvl && ap[CFC_P_LG] && grant[CFC_P_CAP] &&
                       ap[CFC_P_RD];
    grant[CFC_P_SL]  = lvl && ap[CFC_P_SL] && grant[CFC_P_CAP] &&
                       ap[CFC_P_WR];
  end

  // register read mux
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      CFC_CTRL_OFF: begin
        rd_val = {29'h0, s_reg.ctrl};
      end
      CFC_ADDR_LO_OFF: begin
        rd_val = s_reg.src.addr[31:0];
      end
      CFC_ADDR_HI_OFF: begin
        rd_val = s_reg.src.addr[63:32];
      end
      CFC_META_LO_OFF: begin
        rd_val = s_reg.src.meta[31:0];
      end
      CFC_META_HI_OFF: begin
        rd_val = s_reg.src.meta[63:32];
        rd_val[CFC_M_BIT - 32] = hyb && s_reg.src.meta[CFC_M_BIT];
      end
      CFC_TAG_OFF: begin
        rd_val = {31'h0, s_reg.src.tag};
      end
      CFC_OP_OFF: begin
        rd_val = 32'h0000_0000;
      end
      CFC_ACC_LO_OFF: begin
        rd_val = s_reg.acc[31:0];
      end
      CFC_ACC_HI_OFF: begin
        rd_val = s_reg.acc[63:32];
      end
      CFC_STAT_OFF: begin
        rd_val = {22'h0, s_reg.full_perm, s_reg.op_err, s_reg.infinite,
                  s_reg.access_ok, s_reg.malformed, s_reg.valid,
                  s_reg.link_tag, s_reg.res.tag, src_ok,
                  s_reg.src.tag};
      end
      CFC_BASE_LO_OFF: begin
        rd_val = s_reg.base[31:0];
      end
      CFC_BASE_HI_OFF: begin
        rd_val = s_reg.base[63:32];
      end
      CFC_TOP_LO_OFF: begin
        rd_val = s_reg.top[31:0];
      end
      CFC_TOP_HI_OFF: begin
        rd_val = s_reg.top[63:32];
      end
      CFC_RES_LO_OFF: begin
        rd_val = s_reg.res.meta[31:0];
      end
      CFC_RES_HI_OFF: begin
        rd_val = s_reg.res.meta[63:32];
      end
      CFC_PERM_OFF: begin
        rd_val = {19'h0, s_reg.top[64], s_reg.perm_rd};
      end
      CFC_LINK_HI_OFF: begin
        rd_val = s_reg.link_meta[63:32];
      end
      CFC_RADR_LO_OFF: begin
        rd_val = s_reg.res.addr[31:0];
      end
      CFC_RADR_HI_OFF: begin
        rd_val = s_reg.res.addr[63:32];
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // one wait state: pready rises one cycle into the access phase
  assign setup_hit = psel && penable && !s_reg.pready;
  assign done_wr   = psel && penable && s_reg.pready && pwrite;

  always_comb begin
    s_next = s_reg;
    s_next.pready  = setup_hit;
    // error flag stands only beside pready, never beyond the transfer
    s_next.pslverr = setup_hit && !mapped;
    if (setup_hit) begin
      s_next.prdata  = pwrite ? 32'h0000_0000 : rd_val;
    end
    if (done_wr) begin
      case (paddr)
        CFC_CTRL_OFF: begin
          s_next.ctrl = pwdata[2:0];
        end
        CFC_ADDR_LO_OFF: begin
          s_next.src.addr[31:0] = pwdata;
        end
        CFC_ADDR_HI_OFF: begin
          s_next.src.addr[63:32] = pwdata;
        end
        CFC_META_LO_OFF: begin
          s_next.src.meta[31:0] = pwdata;
        end
        CFC_META_HI_OFF: begin
          s_next.src.meta[63:32] = pwdata;
        end
        CFC_TAG_OFF: begin
          s_next.src.tag = pwdata[0];
        end
        CFC_ACC_LO_OFF: begin
          s_next.acc[31:0] = pwdata;
        end
        CFC_ACC_HI_OFF: begin
          s_next.acc[63:32] = pwdata;
        end
        CFC_OP_OFF: begin
          // every operation refreshes the decoded view of the source
          s_next.base      = bnd_src.base;
          s_next.top       = bnd_src.top;
          s_next.malformed = bnd_src.malformed;
          s_next.infinite  = bnd_src.infinite;
          s_next.valid     = src_good;
          s_next.full_perm = ap == CFC_FULL_PERM_VALUE;
          s_next.perm_rd   = {s_reg.src.meta[CFC_SDP_LSB +: CFC_SDP_W],
                              grant};
          s_next.op_err    = 1'b0;
          s_next.res       = s_reg.src;
          s_next.res.tag   = src_good;
          case (cfc_op_e'(pwdata[2:0]))
            CFC_OP_DECODE: begin
              s_next.access_ok = 1'b0;
            end
            CFC_OP_SETADDR: begin
              // bounds must survive the address change exactly
              s_next.res.addr = s_reg.acc;
              s_next.res.tag  = src_good &&
                                bnd_probe.base == bnd_src.base &&
                                bnd_probe.top == bnd_src.top;
            end
            CFC_OP_JUMP: begin
              // sealed and unsealed targets are both attempted
              if (s_reg.src.meta[CFC_CT_BIT]) begin
                s_next.res.meta[CFC_CT_BIT] = 1'b0;
              end
              s_next.link_meta = s_reg.src.meta;
              s_next.link_meta[CFC_CT_BIT] = 1'b1;
              s_next.link_tag = src_good;
            end
            CFC_OP_SENTRY: begin
              if (s_reg.ctrl[CFC_C_SENTRY]) begin
                // type one regardless of what the permissions say
                s_next.res.meta[CFC_CT_BIT] = 1'b1;
              end else begin
                s_next.op_err  = 1'b1;
                s_next.res.tag = 1'b0;
              end
            end
            CFC_OP_CHECK: begin
              s_next.access_ok = src_good &&
                                 s_reg.acc >= bnd_src.base &&
                                 {1'b0, s_reg.acc} < bnd_src.top;
            end
            CFC_OP_BUILD: begin
              // type one is ambient, so either type builds unchanged
              s_next.res.tag = src_good;
            end
            default: begin
              s_next.op_err  = 1'b1;
              s_next.res.tag = 1'b0;
            end
          endcase
        end
        default: begin
          s_next.op_err = s_reg.op_err;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pready  = s_reg.pready;
  assign prdata  = s_reg.prdata;
  assign pslverr = s_reg.pslverr;

endmodule : cfc_codec

// ### cfc_codec_chk.sv
// concurrent checks on the codec's apb ports
`timescale 1ns/1ps
module cfc_codec_chk
  import cfc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  logic [2:0] ctrl_reg;
  logic       lvl_reg;
  logic       wr_done;
  logic       rd_done;

  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;

  // perm readback reflects control at the last op, not the live bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 3'h0;
      lvl_reg  <= 1'b0;
    end else if (wr_done && paddr == CFC_CTRL_OFF) begin
      ctrl_reg <= pwdata[2:0];
    end else if (wr_done && paddr == CFC_OP_OFF) begin
      lvl_reg <= ctrl_reg[CFC_C_LEVELS];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence

  answer_time_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("answer not on second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (access_s and pready |->
    pslverr == (paddr > 8'h4C || paddr[1:0] != 2'b00))
    else $error("pslverr does not match address map");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  mode_hidden_a: assert property (rd_done && paddr == CFC_META_HI_OFF &&
    !ctrl_reg[CFC_C_HYBRID] |-> !prdata[CFC_M_BIT - 32])
    else $error("mode bit visible without hybrid support");
  perm_width_a: assert property (rd_done && paddr == CFC_PERM_OFF
    |-> prdata[31:13] == 19'h0)
    else $error("perm readback wider than its fields");
  levels_perm_a: assert property (rd_done && paddr == CFC_PERM_OFF &&
    !lvl_reg |-> prdata[7:6] == 2'b00)
    else $error("level permissions granted without level support");
  op_read_zero_a: assert property (rd_done && paddr == CFC_OP_OFF
    |-> prdata == 32'h0)
    else $error("op register did not read zero");
  status_width_a: assert property (rd_done && paddr == CFC_STAT_OFF
    |-> prdata[31:10] == 22'h0)
    else $error("status has bits above its fields");
endmodule : cfc_codec_chk

bind cfc_codec cfc_codec_chk cfc_codec_chk_inst (
  .pclk    (pclk),
  .presetn (presetn),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .pwdata  (pwdata),
  .pready  (pready),
  .prdata  (prdata),
  .pslverr (pslverr)
);

// ### cfc_codec_test.sv
// self-checking testbench for the capability format codec
`timescale 1ns/1ps
module cfc_codec_test
  import cfc_pkg::*;
;
  // well-formed source: scale zero, base 0x100, top 0x200, sw perms 0xA
  localparam logic [31:0] VLO = 32'hA480_0100;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [31:0] rdata;
  logic        rerr;
  int          fails;
  int          checked;
  int          cycles;

  cfc_codec cfc_codec_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr)
  );

  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("[ERR] %0t run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chkb(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask : chkb

  // a wait on pready is cut short only by the global cycle ceiling
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdata, exp);
  endtask : rdchk

  task automatic ld(input logic [31:0] lo, input logic [31:0] hi);
    wr(CFC_ADDR_LO_OFF, 32'h0000_0180);
    wr(CFC_ADDR_HI_OFF, 32'h0);
    wr(CFC_META_LO_OFF, lo);
    wr(CFC_META_HI_OFF, hi);
    wr(CFC_TAG_OFF, 32'h1);
  endtask : ld

  task automatic op(input cfc_op_e c);
    wr(CFC_OP_OFF, {29'h0, c});
    rd(CFC_STAT_OFF);
  endtask : op

  task automatic t_reset();
    rdchk(CFC_CTRL_OFF, 32'h0);
    rdchk(CFC_PERM_OFF, 32'h0);
    rdchk(8'h50, 32'h0);
    chkb(rerr, 1'b1);
    wr(8'h54, 32'hFFFF_FFFF);
    chkb(rerr, 1'b1);
    rdchk(CFC_OP_OFF, 32'h0);
  endtask : t_reset

  task automatic t_mode();
    wr(CFC_CTRL_OFF, 32'h0);
    wr(CFC_META_HI_OFF, 32'h0010_00FF);
    rdchk(CFC_META_HI_OFF, 32'h0000_00FF);
    wr(CFC_CTRL_OFF, 32'h1);
    rdchk(CFC_META_HI_OFF, 32'h0010_00FF);
  endtask : t_mode

  task automatic t_valid();
    logic [31:0] hv [6] = '{32'h0000_00FF, 32'h0000_02FF, 32'h0000_007F,
                            32'h0000_01FF, 32'h0010_00F7, 32'h0010_00FF};
    logic        ev [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    wr(CFC_CTRL_OFF, 32'h1);
    for (int i = 0; i < 6; i++) begin
      ld(VLO, hv[i]);
      op(CFC_OP_DECODE);
      chkb(rdata[4], ev[i]);
      chkb(rdata[9], hv[i][7:0] == 8'hFF);
    end
    wr(CFC_CTRL_OFF, 32'h2);
    ld(VLO, 32'h0000_013F);
    op(CFC_OP_DECODE);
    chkb(rdata[4], 1'b1);
    rdchk(CFC_PERM_OFF, 32'h0000_0A3F);
    ld(VLO, 32'h0000_01FF);
    op(CFC_OP_DECODE);
    rdchk(CFC_PERM_OFF, 32'h0000_0AFF);
    ld(VLO, 32'h0000_00F9);
    op(CFC_OP_DECODE);
    chkb(rdata[4], 1'b1);
    rdchk(CFC_PERM_OFF, 32'h0000_0A18);
  endtask : t_valid

  task automatic t_bounds();
    logic [31:0] acc [6] = '{32'hFF, 32'h100, 32'h1FF, 32'h200,
                             32'h3000, 32'h3200};
    logic        ok [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(CFC_CTRL_OFF, 32'h0);
    ld(VLO, 32'h0000_00FF);
    op(CFC_OP_DECODE);
    rdchk(CFC_BASE_LO_OFF, 32'h100);
    rdchk(CFC_BASE_HI_OFF, 32'h0);
    rdchk(CFC_TOP_LO_OFF, 32'h200);
    rdchk(CFC_TOP_HI_OFF, 32'h0);
    rdchk(CFC_PERM_OFF, 32'h0000_0A3F);
    // the last two are either side of the upper representable edge
    for (int i = 0; i < 6; i++) begin
      wr(CFC_ACC_LO_OFF, acc[i]);
      wr(CFC_ACC_HI_OFF, 32'h0);
      op(i < 4 ? CFC_OP_CHECK : CFC_OP_SETADDR);
      chkb(i < 4 ? rdata[6] : rdata[2], ok[i]);
      rdchk(CFC_RADR_LO_OFF, i < 4 ? 32'h0000_0180 : acc[i]);
    end
  endtask : t_bounds

  task automatic t_malformed();
    logic [31:0] lo [5] = '{32'h0080_0100, 32'h0081_C107, 32'h0000_2001,
                            32'h0000_0001, 32'h0000_0000};
    logic [1:0]  ex [5] = '{2'b01, 2'b01, 2'b01, 2'b00, 2'b10};
    for (int i = 0; i < 5; i++) begin
      ld(lo[i], 32'h0000_00FF);
      op(CFC_OP_DECODE);
      chk({30'h0, rdata[7], rdata[5]}, {30'h0, ex[i]});
      rdchk(CFC_BASE_LO_OFF, 32'h0);
    end
  endtask : t_malformed

  task automatic t_seal();
    wr(CFC_CTRL_OFF, 32'h4);
    ld(VLO, 32'h0000_00FF);
    op(CFC_OP_SENTRY);
    chkb(rdata[8], 1'b0);
    rd(CFC_RES_LO_OFF);
    chkb(rdata[CFC_CT_BIT], 1'b1);
    wr(CFC_CTRL_OFF, 32'h0);
    op(CFC_OP_SENTRY);
    chk({30'h0, rdata[8], rdata[2]}, 32'h2);
    wr(CFC_OP_OFF, 32'h6);
    rd(CFC_STAT_OFF);
    chk({30'h0, rdata[8], rdata[2]}, 32'h2);
    for (int c = 0; c < 2; c++) begin
      ld(VLO | {4'h0, c[0], 27'h0}, 32'h0000_00FF);
      op(CFC_OP_JUMP);
      chkb(rdata[3], 1'b1);
      chkb(rdata[8], 1'b0);
      rd(CFC_RES_LO_OFF);
      chkb(rdata[CFC_CT_BIT], 1'b0);
      rdchk(CFC_LINK_HI_OFF, 32'h0000_00FF);
    end
    op(CFC_OP_BUILD);
    chk({30'h0, rdata[8], rdata[2]}, 32'h1);
  endtask : t_seal

  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    fails   = 0;
    checked = 0;
    cycles  = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode();
    t_valid();
    t_bounds();
    t_malformed();
    t_seal();
    tally_and_finish();
  end
endmodule : cfc_codec_test
